// File: design/ldm_drive_mon.sv
`timescale 1ns/1ps
// Per-channel transmit drive monitor; one bit period per clock
module ldm_drive_mon (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_int_sel, // Source select from control register
  input wire logic i_monitor_pos_in, // External monitor, positive rail
  input wire logic i_monitor_neg_in, // External monitor, negative rail
  input wire logic i_pad_pos, // Pad sense of tx_line_pos_out
  input wire logic i_pad_neg, // Pad sense of tx_line_neg_out
  output logic o_drive_monitor_alarm // Alarm level, from a flop
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] meta_q; // First stage, read by second stage only
  logic [3:0] sync_q; // Second stage, safe to use
  logic [7:0] cnt_q; // Silent period counter
  logic [7:0] cnt_d;
  logic alarm_q;
  logic alarm_d;
  wire logic ext_act; // Pulse seen on the external inputs
  wire logic pad_act; // Pulse seen at the pads
  wire logic activity; // Pulse seen on the chosen source
  wire logic at_last; // Final silent period reached

  // All four senses arrive from analog pins, so both stages always run
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= {i_pad_neg, i_pad_pos, i_monitor_neg_in, i_monitor_pos_in};
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Source selection and counting
  // ----------------------------------------------------------------
  // A pulse on either rail counts as bipolar activity
  assign ext_act = sync_q[0] | sync_q[1];
  assign pad_act = sync_q[2] | sync_q[3];
  assign activity = i_int_sel ? pad_act : ext_act;
  assign at_last = (cnt_q == ldm_pkg::SILENT_LAST);
  // Counter saturates at the last value so a long silence holds the alarm
  assign cnt_d = activity ? ldm_pkg::CNT_RESET : (at_last ? cnt_q : cnt_q + 8'h01);
  // Activity wins: the alarm drops at the edge the pulse is seen
  assign alarm_d = activity ? 1'b0 : (alarm_q | at_last);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_q <= ldm_pkg::CNT_RESET;
      alarm_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      alarm_q <= alarm_d;
    end
  end

  assign o_drive_monitor_alarm = alarm_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  alarm_declare_a: assert property (!activity [*8] ##0 at_last |=> alarm_q)
    else $error("alarm not declared after silence");
  alarm_clear_a: assert property (activity |=> !alarm_q)
    else $error("alarm not cleared on activity");
  alarm_early_a: assert property ($rose(alarm_q) |-> $past(cnt_q) == 8'h7F)
    else $error("alarm declared early");
  pad_source_a: assert property (i_int_sel && pad_act |=> cnt_q == 8'h00)
    else $error("pad activity ignored");
  ext_source_a: assert property (!i_int_sel && ext_act |=> cnt_q == 8'h00)
    else $error("external activity ignored");
  ext_ignored_a: assert property (i_int_sel && !pad_act && !at_last |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("external input not ignored");

  silence_c: cover property (!activity [*8] ##1 $rose(alarm_q));
  recover_c: cover property (alarm_q ##1 !alarm_q);
  internal_c: cover property (i_int_sel && pad_act && alarm_q);

endmodule : ldm_drive_mon

// File: design/ldm_pkg.sv
package ldm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TXCTL_CH0 = 8'h04; // Transmit control, channel 0
  localparam logic [7:0] ADDR_TXCTL_CH1 = 8'h0C; // Transmit control, channel 1
  localparam logic [7:0] ADDR_STAT_CH0 = 8'h03; // Alarm status, channel 0
  localparam logic [7:0] ADDR_STAT_CH1 = 8'h0B; // Alarm status, channel 1

  // ----------------------------------------------------------------
  // Transmit control fields
  // ----------------------------------------------------------------
  localparam int TXCTL_INT_MON_BIT = 5; // Internal monitor select
  localparam int TXCTL_INS_ERR_BIT = 4; // Insert-error trigger
  localparam int TXCTL_ALL_ONES_BIT = 2; // Transmit all ones
  localparam int TXCTL_CLK_EDGE_BIT = 1; // Clock edge select
  localparam int TXCTL_LEVEL_BIT = 0; // Level select
  localparam logic [7:0] TXCTL_RW_MASK = 8'h37; // Bits 7, 6, 3 stay zero
  localparam logic [7:0] TXCTL_RESET = 8'h00; // Value after reset

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int STAT_LOS_BIT = 1; // Receive LOS declared
  localparam int STAT_DMO_BIT = 0; // Drive monitor alarm declared
  localparam logic [7:0] REG_ZERO = 8'h00; // Unmapped read value

  // ----------------------------------------------------------------
  // Line rate codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_LOW = 2'h0; // Lowest rate, standards detector
  localparam logic [1:0] RATE_MID = 2'h1; // Middle rate
  localparam logic [1:0] RATE_HIGH = 2'h2; // Highest rate

  // ----------------------------------------------------------------
  // Drive monitor timing, in bit periods of the line clock
  // ----------------------------------------------------------------
  localparam int SILENT_BITS = 128; // Silent periods before alarm
  localparam logic [7:0] SILENT_LAST = 8'(SILENT_BITS - 1); // Count at declare
  localparam logic [7:0] CNT_RESET = 8'h00; // Counter after reset

endpackage : ldm_pkg

// File: design/ldm_status_bank.sv
`timescale 1ns/1ps
// Two-channel LOS status and transmit drive monitor register bank
module ldm_status_bank #(
  parameter int NUM_CH = 2 // Channels with a mapped control register
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Register port
  input wire logic i_reg_wr, // Write strobe, one cycle
  input wire logic i_reg_rd, // Read strobe, one cycle
  input wire logic [7:0] i_reg_addr, // Register offset
  input wire logic [7:0] i_reg_wdata, // Write data
  output logic [7:0] o_reg_rdata, // Read data, valid after read strobe
  output logic o_reg_rvalid, // Read data valid pulse
  // Receive detectors, per channel
  input wire logic [1:0] i_rate_ch0, // Line rate code, channel 0
  input wire logic [1:0] i_rate_ch1, // Line rate code, channel 1
  input wire logic [1:0] i_los_digital, // Digital detector declaring
  input wire logic [1:0] i_los_analog, // Analog amplitude detector declaring
  input wire logic [1:0] i_los_std, // Standards-based detector declaring
  // Drive monitor senses, per channel
  input wire logic [1:0] i_monitor_pos_in,
  input wire logic [1:0] i_monitor_neg_in,
  input wire logic [1:0] i_pad_pos,
  input wire logic [1:0] i_pad_neg,
  // Status and settings
  output logic [1:0] o_rx_los, // Receive LOS declared
  output logic [1:0] o_drive_monitor_alarm, // Drive monitor alarm declared
  output logic [1:0] o_transmit_all_ones, // All-ones enable
  output logic [1:0] o_tx_clock_edge_select, // Clock edge select
  output logic [1:0] o_tx_level_select, // Level select
  output logic [1:0] o_insert_error_pulse // One cycle per 0-to-1 write
);

  // Only two control copies are mapped, so refuse any other count
  if (NUM_CH != 2) begin : g_bad_ch
    $error("ldm_status_bank maps exactly two channels");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] txctl_q [2]; // Transmit control copies
  logic [7:0] txctl_d [2];
  logic [1:0] los_meta_q [3]; // First stage of detector syncs
  logic [1:0] los_sync_q [3]; // Second stage: digital, analog, standards
  logic [1:0] los_q; // Combined LOS per channel
  logic [1:0] ins_pulse_q; // Insert-error trigger pulses
  logic [7:0] rdata_q;
  logic rvalid_q;
  wire logic [1:0] rate [2]; // Rate code per channel
  wire logic [1:0] los_d; // Combined LOS next value
  wire logic [1:0] wr_hit; // Write hits a control copy
  wire logic [1:0] ins_rise; // Trigger bit going 0 to 1
  wire logic [1:0] drive_monitor_alarm; // Alarms from the monitors
  wire logic [7:0] stat [2]; // Status register images
  wire logic [7:0] rdata_d; // Selected read value

  assign rate[0] = i_rate_ch0;
  assign rate[1] = i_rate_ch1;

  // ----------------------------------------------------------------
  // Receive LOS combination
  // ----------------------------------------------------------------
  // Detector flags come from another timing domain, so sync them first
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      los_meta_q <= '{2'h0, 2'h0, 2'h0};
      los_sync_q <= '{2'h0, 2'h0, 2'h0};
    end else begin
      los_meta_q <= '{i_los_digital, i_los_analog, i_los_std};
      los_sync_q <= los_meta_q;
    end
  end

  // Only the detectors valid for the chosen rate take part; others are
  // masked so an idle detector at the wrong rate cannot raise LOS
  for (genvar c = 0; c < 2; c++) begin : g_los
    assign los_d[c] = (rate[c] == ldm_pkg::RATE_LOW) ? los_sync_q[2][c]
                    : (los_sync_q[0][c] | los_sync_q[1][c]);
  end

  // Plain follower, never sticky
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      los_q <= 2'h0;
    end else begin
      los_q <= los_d;
    end
  end

  // ----------------------------------------------------------------
  // Transmit control registers
  // ----------------------------------------------------------------
  assign wr_hit[0] = i_reg_wr && (i_reg_addr == ldm_pkg::ADDR_TXCTL_CH0);
  assign wr_hit[1] = i_reg_wr && (i_reg_addr == ldm_pkg::ADDR_TXCTL_CH1);

  for (genvar c = 0; c < 2; c++) begin : g_ctl
    // Unused bits are masked on write, so they always read zero
    assign txctl_d[c] = wr_hit[c] ? (i_reg_wdata & ldm_pkg::TXCTL_RW_MASK) : txctl_q[c];
    // Trigger fires on the written rising edge; software clears it later
    assign ins_rise[c] = wr_hit[c] && i_reg_wdata[ldm_pkg::TXCTL_INS_ERR_BIT]
                       && !txctl_q[c][ldm_pkg::TXCTL_INS_ERR_BIT];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      txctl_q <= '{ldm_pkg::TXCTL_RESET, ldm_pkg::TXCTL_RESET};
      ins_pulse_q <= 2'h0;
    end else begin
      txctl_q <= txctl_d;
      ins_pulse_q <= ins_rise;
    end
  end

  // ----------------------------------------------------------------
  // Drive monitors
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_dm
    ldm_drive_mon u_mon (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_int_sel(txctl_q[c][ldm_pkg::TXCTL_INT_MON_BIT]),
      .i_monitor_pos_in(i_monitor_pos_in[c]),
      .i_monitor_neg_in(i_monitor_neg_in[c]),
      .i_pad_pos(i_pad_pos[c]),
      .i_pad_neg(i_pad_neg[c]),
      .o_drive_monitor_alarm(drive_monitor_alarm[c])
    );
    // Status image: live LOS and alarm, rest zero
    assign stat[c] = {6'h00, los_q[c], drive_monitor_alarm[c]};
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Status registers have no write path: writes there are dropped
  assign rdata_d = (i_reg_addr == ldm_pkg::ADDR_TXCTL_CH0) ? txctl_q[0]
                 : (i_reg_addr == ldm_pkg::ADDR_TXCTL_CH1) ? txctl_q[1]
                 : (i_reg_addr == ldm_pkg::ADDR_STAT_CH0) ? stat[0]
                 : (i_reg_addr == ldm_pkg::ADDR_STAT_CH1) ? stat[1]
                 : ldm_pkg::REG_ZERO;

  // Data held until the next read
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_q <= ldm_pkg::REG_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_reg_rd;
      if (i_reg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;
  assign o_rx_los = los_q;
  assign o_drive_monitor_alarm = drive_monitor_alarm;
  assign o_insert_error_pulse = ins_pulse_q;
  for (genvar c = 0; c < 2; c++) begin : g_out
    assign o_transmit_all_ones[c] = txctl_q[c][ldm_pkg::TXCTL_ALL_ONES_BIT];
    assign o_tx_clock_edge_select[c] = txctl_q[c][ldm_pkg::TXCTL_CLK_EDGE_BIT];
    assign o_tx_level_select[c] = txctl_q[c][ldm_pkg::TXCTL_LEVEL_BIT];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  los_low_rate_a: assert property (rate[0] == 2'h0 |=> o_rx_los[0] == $past(los_sync_q[2][0]))
    else $error("low rate LOS wrong");
  los_high_rate_a: assert property (rate[1] != 2'h0 |=>
    o_rx_los[1] == $past(los_sync_q[0][1] | los_sync_q[1][1]))
    else $error("high rate LOS wrong");
  los_any_a: assert property (rate[0] != 2'h0 && los_sync_q[1][0] |=> o_rx_los[0])
    else $error("analog LOS not reported");
  los_follow_a: assert property ($fell(los_d[0]) |=> !o_rx_los[0])
    else $error("LOS status latched");
  ctl_unused_a: assert property (((txctl_q[0] | txctl_q[1]) & ~ldm_pkg::TXCTL_RW_MASK) == 8'h00)
    else $error("unused control bit set");
  ctl_write_a: assert property (wr_hit[1] |=> txctl_q[1] == ($past(i_reg_wdata) & 8'h37))
    else $error("control write lost");
  ctl_indep_a: assert property (wr_hit[0] && !wr_hit[1] |=> $stable(txctl_q[1]))
    else $error("channel copies not independent");
  stat_read_a: assert property (i_reg_rd && i_reg_addr == 8'h03 |=> o_reg_rdata[0] == $past(drive_monitor_alarm[0]))
    else $error("alarm status read wrong");

  write_read_c: cover property (wr_hit[0] ##1 i_reg_rd && i_reg_addr == 8'h04);
  los_c: cover property (o_rx_los == 2'h3);
  insert_c: cover property (o_insert_error_pulse[1]);

endmodule : ldm_status_bank

// File: verif/ldm_line_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Transmit line model: output pads and the optional external tap
// ----------------------------------------------------------------
module ldm_line_model (
  input wire logic [1:0] i_drive_pos, // Pulse driven on positive rail
  input wire logic [1:0] i_drive_neg, // Pulse driven on negative rail
  input wire logic i_ext_wired, // Monitor inputs tied to the line
  input wire logic [1:0] i_noise, // Stray pulses on the monitor tap
  output logic [1:0] o_pad_pos,
  output logic [1:0] o_pad_neg,
  output logic [1:0] o_mon_pos,
  output logic [1:0] o_mon_neg
);
  // Pads always show the line; an idle line carries no pulse
  assign o_pad_pos = i_drive_pos;
  assign o_pad_neg = i_drive_neg;
  // Unwired tap sees only noise, so a wrong source choice shows
  assign o_mon_pos = (i_ext_wired ? i_drive_pos : 2'h0) | i_noise;
  assign o_mon_neg = i_ext_wired ? i_drive_neg : 2'h0;
endmodule : ldm_line_model

// File: verif/tb_los_and_drive_monitor_status.sv
`timescale 1ns/1ps
module tb_los_and_drive_monitor_status;
  typedef struct packed {logic [1:0] rate; logic dig; logic ana; logic std; logic los;} ldm_row_t;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, wired = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  logic rvalid;
  logic [1:0] rate = 2'h0, dig = 2'h0, ana = 2'h0, std = 2'h0, dp = 2'h0, dn = 2'h0, noise = 2'h0;
  logic [1:0] pp, pn, mp, mn, los, alarm, aones, edg, lev, ins;
  int mismatches = 0, check_count = 0;
  logic [7:0] raddr [5] = '{8'h04, 8'h0C, 8'h03, 8'h0B, 8'h20};
  ldm_row_t rows [7] = '{'{2'h0, 1'b1, 1'b1, 1'b0, 1'b0}, '{2'h0, 1'b0, 1'b0, 1'b1, 1'b1},
    '{2'h1, 1'b1, 1'b0, 1'b0, 1'b1}, '{2'h1, 1'b0, 1'b1, 1'b0, 1'b1}, '{2'h1, 1'b0, 1'b0, 1'b1, 1'b0},
    '{2'h2, 1'b0, 1'b1, 1'b0, 1'b1}, '{2'h2, 1'b0, 1'b0, 1'b0, 1'b0}};
  ldm_status_bank ldm_status_bank_i (.i_clk_sys(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_rate_ch0(rate), .i_rate_ch1(rate), .i_los_digital(dig), .i_los_analog(ana), .i_los_std(std),
    .i_monitor_pos_in(mp), .i_monitor_neg_in(mn), .i_pad_pos(pp), .i_pad_neg(pn), .o_rx_los(los),
    .o_drive_monitor_alarm(alarm), .o_transmit_all_ones(aones), .o_tx_clock_edge_select(edg),
    .o_tx_level_select(lev), .o_insert_error_pulse(ins));
  ldm_line_model ldm_line_model_i (.i_drive_pos(dp), .i_drive_neg(dn), .i_ext_wired(wired),
    .i_noise(noise), .o_pad_pos(pp), .o_pad_neg(pn), .o_mon_pos(mp), .o_mon_neg(mn));
  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Whole run is near 350 cycles; allow plenty of slack
  initial begin
    #75000;
    mismatches++;
    test_done();
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic chk_two(input string nm, input logic [1:0] e, input logic [1:0] g);
    chk_byte(nm, {6'h00, e}, {6'h00, g});
  endtask : chk_two
  // Strobes last exactly one cycle, as the port expects
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #2 wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk) #2 wr = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #2 rd = 1'b1;
    addr = a;
    @(posedge clk) #2 rd = 1'b0;
    chk_two("rvalid", 2'h1, {1'b0, rvalid});
    d = rdata;
  endtask : reg_rd
  // One-cycle line pulse; returns just after the sampling edge
  task automatic pulse(input logic [1:0] p, input logic [1:0] n, input logic [1:0] z);
    @(posedge clk) #2 dp = p;
    dn = n;
    noise = z;
    @(posedge clk) #2 dp = 2'h0;
    dn = 2'h0;
    noise = 2'h0;
  endtask : pulse
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    #2 rst = 1'b0;
    chk_two("alarm_rst", 2'h0, alarm);
    chk_two("los_rst", 2'h0, los);
    foreach (raddr[k]) begin
      reg_rd(raddr[k], v);
      chk_byte("reset_read", 8'h00, v);
    end
    // Detector combinations per rate, both channels together
    foreach (rows[i]) begin
      @(posedge clk) #2 rate = rows[i].rate;
      {dig, ana, std} = {{2{rows[i].dig}}, {2{rows[i].ana}}, {2{rows[i].std}}};
      repeat (3) @(posedge clk);
      #2 chk_two("rx_los", {2{rows[i].los}}, los);
      reg_rd(i[0] ? ldm_pkg::ADDR_STAT_CH1 : ldm_pkg::ADDR_STAT_CH0, v);
      chk_two("los_bit", {1'b0, rows[i].los}, {1'b0, v[ldm_pkg::STAT_LOS_BIT]});
    end
    // Control fields, reserved bits and the insert-error edge
    reg_wr(8'h04, 8'hFF);
    chk_two("ins_pulse", 2'h1, ins);
    chk_byte("ctl_out", 8'h15, {2'h0, aones, edg, lev});
    @(posedge clk) #2 chk_two("ins_end", 2'h0, ins);
    reg_rd(8'h04, v);
    chk_byte("ctl0", 8'h37, v);
    reg_wr(8'h0C, 8'h05);
    reg_wr(8'h04, 8'hEF);
    chk_two("ins_none", 2'h0, ins);
    reg_wr(8'h20, 8'hFF);
    reg_rd(8'h04, v);
    chk_byte("ctl0b", 8'h27, v);
    reg_rd(8'h0C, v);
    chk_byte("ctl1", 8'h05, v);
    reg_wr(8'h0C, 8'h15);
    chk_two("ins_pulse1", 2'h2, ins);
    reg_rd(8'h20, v);
    chk_byte("unmapped", 8'h00, v);
    reg_wr(8'h04, 8'h00);
    // Silent line from reset: wait past 128 silent periods plus sync delay
    repeat (100) @(posedge clk);
    #2 chk_two("alarm_up", 2'h3, alarm);
    reg_rd(8'h03, v);
    chk_two("alarm_bit", 2'h1, {1'b0, v[ldm_pkg::STAT_DMO_BIT]});
    // External source, wired tap: clear, then exact re-arm
    pulse(2'h1, 2'h0, 2'h0);
    repeat (2) @(posedge clk);
    #2 chk_two("alarm_clr", 2'h2, alarm);
    reg_rd(8'h03, v);
    chk_two("alarm_bit0", 2'h0, {1'b0, v[ldm_pkg::STAT_DMO_BIT]});
    repeat (125) @(posedge clk);
    #2 chk_two("alarm_127", 2'h2, alarm);
    @(posedge clk) #2 chk_two("alarm_128", 2'h3, alarm);
    // Unwired tap: pad pulses must not reach the monitor
    wired = 1'b0;
    pulse(2'h0, 2'h1, 2'h0);
    repeat (4) @(posedge clk);
    #2 chk_two("ext_ign", 2'h3, alarm);
    // Internal source: tap noise ignored, pad neg rail clears
    reg_wr(8'h04, 8'h20);
    pulse(2'h0, 2'h0, 2'h1);
    repeat (4) @(posedge clk);
    #2 chk_two("noise_ign", 2'h3, alarm);
    pulse(2'h0, 2'h1, 2'h0);
    repeat (2) @(posedge clk);
    #2 chk_two("pad_clr", 2'h2, alarm);
    // Reset in mid-run: alarm and the channel 0 control copy back to zero
    @(posedge clk) #2 rst = 1'b1;
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    chk_two("alarm_rst2", 2'h0, alarm);
    reg_rd(8'h04, v);
    chk_byte("ctl_rst2", 8'h00, v);
    test_done();
  end
endmodule : tb_los_and_drive_monitor_status
